// ---- nipc_top.sv ----
// nested interrupt priority controller with apb register access
//
// Contract
// R1: priority bits 5,3 encode four levels
// R2: entry loads serviced vector's stored pair
// R3: instructions load 10, 11 or restore
// R4: emergency stop, trap, reset break level 3
// R5: banks reset ones; bank3 high nibble ones
// R6: pairs packed ascending, pair 0 lowest address
// R7: writing level-0 code keeps that pair
// R8: reset, trap, emergency stop set 11
// R9: emergency stop pair stored but ignored
// R10: changed priority re-enters only if higher
// R11: flag reports priority bits equal 11
// R12: instruction-set level persists until next change
// R13: fixed order vector 0 highest to 13
// R14: halt wake only by listed vectors
// R15: changed sense write clears external pending
// R16: grounded interrupt pin masks its vector
// R17: edge, both, low-level, inverted high-level modes
// R18: sense fields writable only at level 3
// R19: sense register field layout
// R20: sense code meanings and inversion swap
// R21: port c inversion affects c3..c1 only
// R22: port c polarity writable only at level 3
// R23: highest software priority first, ties fixed
// R24: serviced only if above current level
// R25: edge latched, cleared on entry, pins ored
// R26: level request follows pin, no latch
//
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/100ps
`include "nipc_regs.svh"
module nipc_top
    import nipc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [13:0] src_req,
    input wire logic [15:0] ext_pin,
    input wire logic [15:0] ext_pin_sel,
    input wire logic [15:0] ext_pin_forced_low,
    input wire logic halt_mode,
    input wire logic active_halt,
    input wire logic enable_irq_instr,
    input wire logic disable_irq_instr,
    input wire logic instr_halt,
    input wire logic wait_for_irq_instr,
    input wire logic instr_trap,
    input wire logic instr_restore,
    input wire logic [1:0] restore_prio,
    input wire logic irq_ack,
    output logic irq_req,
    output logic [3:0] irq_vector,
    output logic [15:0] irq_vector_addr,
    output logic wake_req,
    output logic priority_upper_bit,
    output logic priority_lower_bit,
    output logic branch_if_masked,
    output logic branch_if_unmasked
);
    localparam logic [15:0] PIN_EI0 = `NIPC_PIN_EI0;
    localparam logic [15:0] PIN_EI1 = `NIPC_PIN_EI1;
    localparam logic [15:0] PIN_EI2 = `NIPC_PIN_EI2;
    localparam logic [15:0] PIN_PD = `NIPC_PIN_PD_INV;
    localparam logic [15:0] PIN_PC = `NIPC_PIN_PC_INV;
    localparam logic [13:0] WAKE_ANY = `NIPC_WAKE_ANY;
    localparam logic [13:0] WAKE_ACT = `NIPC_WAKE_ACTIVE;

    nipc_state_t st;
    nipc_state_t next_st;
    logic [15:0] pin_level;
    logic [15:0] pin_prev;
    logic [15:0] pin_edge;
    logic [15:0] pin_lvl;
    logic [2:0] grp_edge;
    logic [2:0] grp_lvl;
    logic [2:0] grp_mask;
    logic [13:0] req;
    logic [13:0] cand;
    logic [13:0] halt_mask;
    logic found;
    logic [3:0] best_v;
    logic [2:0] best_l;
    logic wr_acc;
    logic rd_setup;
    logic ext_wr_ok;
    logic ext_changed;
    logic [1:0] ack_pair;

    // byte address of a register index, aligned words only
    function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
        hit = (a == {2'b00, idx, 2'b00});
    endfunction : hit

    // ordinal of a priority code: level 0 lowest, level 3 highest
    function automatic logic [2:0] lvl_of(input logic [1:0] code);
        case (code)
            2'b10: lvl_of = 3'd1;
            2'b01: lvl_of = 3'd2;
            2'b00: lvl_of = 3'd3;
            default: lvl_of = 3'd4;
        endcase
    endfunction : lvl_of

    // pair v out of the four banks, packed ascending
    function automatic logic [1:0] pair_of(input logic [27:0] banks, input logic [3:0] v);
        pair_of = banks[{v, 1'b0} +: 2];
    endfunction : pair_of

    // a pair written with the level-0 code keeps its old value
    function automatic logic [7:0] merge_pairs(input logic [7:0] old, input logic [7:0] wr);
        logic [7:0] res;
        res = wr;
        for (int k = 0; k < 4; k++) begin
            if (wr[2*k +: 2] == `NIPC_LVL0) begin
                res[2*k +: 2] = old[2*k +: 2];
            end
        end
        merge_pairs = res;
    endfunction : merge_pairs

    // {edge, level} hit of one pin for a sense code and inversion
    function automatic logic [1:0] sense_hit(input logic [1:0] code, input logic inv,
                                             input logic cur, input logic prev);
        logic rise;
        logic fall;
        rise = ~prev & cur;
        fall = prev & ~cur;
        case (code)
            2'b00: sense_hit = inv ? {rise, cur} : {fall, ~cur};
            2'b01: sense_hit = {(inv ? fall : rise), 1'b0};
            2'b10: sense_hit = {(inv ? rise : fall), 1'b0};
            default: sense_hit = {rise | fall, 1'b0};
        endcase
    endfunction : sense_hit

    nipc_pin_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin_async(ext_pin),
        .pin_level(pin_level),
        .pin_prev(pin_prev)
    );

    // per-pin sensitivity decode
    always_comb begin
        logic [1:0] code;
        logic inv;
        logic [1:0] h;
        code = 2'b00;
        inv = 1'b0;
        h = 2'b00;
        for (int i = 0; i < 16; i++) begin
            // R19 field select
            if (PIN_EI0[i]) begin
                code = st.ext_sense[`NIPC_G0_SENSE];
            end else if (PIN_EI1[i]) begin
                code = st.ext_sense[`NIPC_G1_SENSE];
            end else begin
                code = st.ext_sense[`NIPC_G2_SENSE];
            end
            // R21 inversion subsets
            inv = (PIN_PD[i] & st.ext_sense[`NIPC_PD_INV]) |
                  (PIN_PC[i] & st.ext_sense[`NIPC_PC_INV]);
            // R17 R20 mode decode
            h = sense_hit(code, inv, pin_level[i], pin_prev[i]);
            pin_edge[i] = h[1] & ext_pin_sel[i];
            pin_lvl[i] = h[0] & ext_pin_sel[i];
        end
    end

    // R25 pins of a group are ored
    assign grp_edge = {|(pin_edge & PIN_EI2), |(pin_edge & PIN_EI1), |(pin_edge & PIN_EI0)};
    assign grp_lvl = {|(pin_lvl & PIN_EI2), |(pin_lvl & PIN_EI1), |(pin_lvl & PIN_EI0)};
    // R16 grounded interrupt pin masks the vector
    assign grp_mask = {|(ext_pin_sel & ext_pin_forced_low & PIN_EI2),
                       |(ext_pin_sel & ext_pin_forced_low & PIN_EI1),
                       |(ext_pin_sel & ext_pin_forced_low & PIN_EI0)};

    // R26 level request needs no latch
    always_comb begin
        req = src_req;
        req[`NIPC_VEC_EI0] = (src_req[`NIPC_VEC_EI0] | st.ext_latch[0] | grp_lvl[0]) & ~grp_mask[0];
        req[`NIPC_VEC_EI1] = (src_req[`NIPC_VEC_EI1] | st.ext_latch[1] | grp_lvl[1]) & ~grp_mask[1];
        req[`NIPC_VEC_EI2] = (src_req[`NIPC_VEC_EI2] | st.ext_latch[2] | grp_lvl[2]) & ~grp_mask[2];
    end

    // R14 only wake-capable vectors while halted
    assign halt_mask = halt_mode ? (WAKE_ANY | (active_halt ? WAKE_ACT : 14'h0000)) : 14'h3fff;

    // arbitration over the fourteen vectors
    always_comb begin
        logic [2:0] l;
        l = 3'd0;
        best_l = 3'd0;
        best_v = 4'h0;
        found = 1'b0;
        cand = 14'h0000;
        for (int v = 0; v < `NIPC_NUM_VEC; v++) begin
            // R9 R4 emergency stop ranks above all stored levels
            l = (v == 0) ? 3'd5 : lvl_of(pair_of({st.bank3_lo, st.bank2, st.bank1, st.bank0},
                                                 4'(v)));
            // R24 R10 only above current level
            cand[v] = req[v] & halt_mask[v] & (l > lvl_of(st.cc));
            // R23 R13 strict compare keeps lower index on ties
            if (cand[v] && l > best_l) begin
                best_l = l;
                best_v = 4'(v);
                found = 1'b1;
            end
        end
    end

    assign ack_pair = pair_of({st.bank3_lo, st.bank2, st.bank1, st.bank0}, st.irq_vec);
    assign wr_acc = psel & penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    // R18 R22 whole sense register locked below level 3
    assign ext_wr_ok = wr_acc & hit(paddr, `NIPC_IDX_EXT) & (st.cc == `NIPC_LVL3);
    assign ext_changed = pwdata[7:0] != st.ext_sense;

    always_comb begin
        next_st = st;
        // R6 register writes
        if (wr_acc && hit(paddr, `NIPC_IDX_BANK0)) begin
            // R7 level-0 code refused per pair
            next_st.bank0 = merge_pairs(st.bank0, pwdata[7:0]);
        end
        if (wr_acc && hit(paddr, `NIPC_IDX_BANK1)) begin
            next_st.bank1 = merge_pairs(st.bank1, pwdata[7:0]);
        end
        if (wr_acc && hit(paddr, `NIPC_IDX_BANK2)) begin
            next_st.bank2 = merge_pairs(st.bank2, pwdata[7:0]);
        end
        if (wr_acc && hit(paddr, `NIPC_IDX_BANK3)) begin
            // R5 high nibble has no storage
            next_st.bank3_lo = 4'(merge_pairs({`NIPC_BANK3_RO, st.bank3_lo}, pwdata[7:0]));
        end
        if (ext_wr_ok) begin
            next_st.ext_sense = pwdata[7:0];
        end
        // R15 changed write drops pending edges
        if (ext_wr_ok && ext_changed) begin
            next_st.ext_latch = 3'b000;
        end
        // R25 entry clears the serviced group latch
        if (irq_ack && st.irq_vec == `NIPC_VEC_EI0) begin
            next_st.ext_latch[0] = 1'b0;
        end
        if (irq_ack && st.irq_vec == `NIPC_VEC_EI1) begin
            next_st.ext_latch[1] = 1'b0;
        end
        if (irq_ack && st.irq_vec == `NIPC_VEC_EI2) begin
            next_st.ext_latch[2] = 1'b0;
        end
        // new edges win over any clear in the same cycle
        next_st.ext_latch = next_st.ext_latch | grp_edge;
        // current priority, entry first since it ends the instruction stream
        if (irq_ack) begin
            // R8 emergency stop enters at level 3
            if (st.irq_vec == `NIPC_VEC_MOTOR_EMERGENCY_STOP) begin
                next_st.cc = `NIPC_LVL3;
            end else begin
                // R2 stored pair loaded on entry
                next_st.cc = ack_pair;
            end
        end else if (instr_restore) begin
            // R3 R12 return and pop restore
            next_st.cc = restore_prio;
        end else if (instr_trap || disable_irq_instr) begin
            // R3 R8 trap and disable load 11
            next_st.cc = `NIPC_LVL3;
        end else if (enable_irq_instr || instr_halt || wait_for_irq_instr) begin
            // R3 R12 enable, halt, wait load 10
            next_st.cc = `NIPC_LVL0;
        end
        // request withdrawn on ack so a stale vector is never offered twice
        next_st.irq_req = found & ~irq_ack;
        next_st.irq_vec = best_v;
        next_st.vec_addr = `NIPC_VEC_BASE - {11'h000, best_v, 1'b0};
        next_st.wake = halt_mode & found;
        if (rd_setup) begin
            if (hit(paddr, `NIPC_IDX_BANK0)) begin
                next_st.rdata = st.bank0;
            end else if (hit(paddr, `NIPC_IDX_BANK1)) begin
                next_st.rdata = st.bank1;
            end else if (hit(paddr, `NIPC_IDX_BANK2)) begin
                next_st.rdata = st.bank2;
            end else if (hit(paddr, `NIPC_IDX_BANK3)) begin
                // R5 read-only ones above the stored pairs
                next_st.rdata = {`NIPC_BANK3_RO, st.bank3_lo};
            end else if (hit(paddr, `NIPC_IDX_EXT)) begin
                next_st.rdata = st.ext_sense;
            end else if (hit(paddr, `NIPC_IDX_STATUS)) begin
                next_st.rdata = {st.cc, st.wake, st.irq_req, st.irq_vec};
            end else begin
                next_st.rdata = 8'h00;
            end
        end
    end

    // R5 banks reset to all ones, priority starts at level 3
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '{bank0: `NIPC_BANK_RST, bank1: `NIPC_BANK_RST, bank2: `NIPC_BANK_RST,
                    bank3_lo: 4'hf, ext_sense: `NIPC_EXT_RST, cc: `NIPC_CC_RST,
                    ext_latch: 3'b000, irq_req: 1'b0, irq_vec: 4'h0,
                    vec_addr: `NIPC_VEC_BASE, wake: 1'b0, rdata: 8'h00};
        end else begin
            st <= next_st;
        end
    end

    // zero wait states keep the slave simple; read data is caught in setup
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~(hit(paddr, `NIPC_IDX_BANK0) | hit(paddr, `NIPC_IDX_BANK1) |
                     hit(paddr, `NIPC_IDX_BANK2) | hit(paddr, `NIPC_IDX_BANK3) |
                     hit(paddr, `NIPC_IDX_EXT) | hit(paddr, `NIPC_IDX_STATUS));
    assign prdata = {24'h000000, st.rdata};
    assign irq_req = st.irq_req;
    assign irq_vector = st.irq_vec;
    assign irq_vector_addr = st.vec_addr;
    assign wake_req = st.wake;
    // R1 upper bit is cc bit 5, lower bit cc bit 3
    assign priority_upper_bit = st.cc[1];
    assign priority_lower_bit = st.cc[0];
    // R11 masked flag for the conditional branches
    assign branch_if_masked = (st.cc == `NIPC_LVL3);
    assign branch_if_unmasked = ~branch_if_masked;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    AST_ENTRY_LOAD: assert property ( // R2
        irq_ack && st.irq_vec != `NIPC_VEC_MOTOR_EMERGENCY_STOP |=>
        {priority_upper_bit, priority_lower_bit} == $past(ack_pair))
        else $error("entry did not load stored pair");

    AST_MOTOR_EMERGENCY_STOP_LEVEL3: assert property ( // R8
        irq_ack && st.irq_vec == `NIPC_VEC_MOTOR_EMERGENCY_STOP |=> branch_if_masked)
        else $error("emergency stop entry not at level 3");

    AST_ENABLE_LOADS: assert property ( // R3
        enable_irq_instr && !irq_ack && !instr_restore && !instr_trap && !disable_irq_instr
        |=> {priority_upper_bit, priority_lower_bit} == 2'b10 && !branch_if_masked)
        else $error("enable did not load level 0");

    AST_PAIR_KEEP: assert property ( // R7
        wr_acc && hit(paddr, `NIPC_IDX_BANK0) && pwdata[1:0] == 2'b10
        |=> st.bank0[1:0] == $past(st.bank0[1:0]))
        else $error("level-0 pair write was stored");

    AST_BANK3_HIGH: assert property ( // R5
        $past(psel && !penable) && psel && penable && !pwrite && hit(paddr, `NIPC_IDX_BANK3)
        |-> prdata[7:4] == 4'hf)
        else $error("bank3 high nibble not ones");

    AST_SENSE_LOCK: assert property ( // R18
        wr_acc && hit(paddr, `NIPC_IDX_EXT) && !branch_if_masked |=> $stable(st.ext_sense))
        else $error("sense written below level 3");

    AST_MOTOR_EMERGENCY_STOP_PREEMPT: assert property ( // R4
        src_req[0] && branch_if_masked && !halt_mode && !irq_ack
        |=> irq_req && irq_vector == 4'h0 ##0 irq_vector_addr == 16'hfffa)
        else $error("emergency stop did not break level 3");

    AST_SENSE_CLEAR: assert property ( // R15
        ext_wr_ok && ext_changed && grp_edge == 3'b000 |=> st.ext_latch == 3'b000)
        else $error("changed sense write kept pending edges");

    AST_HALT_WAKE: assert property ( // R14
        $past(halt_mode) && !$past(active_halt) && irq_req |-> WAKE_ANY[irq_vector])
        else $error("non-wake vector offered in halt");
endmodule : nipc_top

// ---- nipc_regs.svh ----
// register indices, field positions, reset values and codes of the priority controller
`ifndef NIPC_REGS_SVH
`define NIPC_REGS_SVH
`define NIPC_IDX_BANK0 8'h24
`define NIPC_IDX_BANK1 8'h25
`define NIPC_IDX_BANK2 8'h26
`define NIPC_IDX_BANK3 8'h27
`define NIPC_IDX_EXT 8'h28
`define NIPC_IDX_STATUS 8'h30
`define NIPC_BANK_RST 8'hff
`define NIPC_BANK3_RO 4'hf
`define NIPC_EXT_RST 8'h00
`define NIPC_CC_RST 2'b11
`define NIPC_LVL0 2'b10
`define NIPC_LVL3 2'b11
`define NIPC_G2_SENSE 7:6
`define NIPC_PC_INV 5
`define NIPC_G1_SENSE 4:3
`define NIPC_G0_SENSE 2:1
`define NIPC_PD_INV 0
`define NIPC_VEC_BASE 16'hfffa
`define NIPC_VEC_MOTOR_EMERGENCY_STOP 4'h0
`define NIPC_VEC_EI0 4'h2
`define NIPC_VEC_EI1 4'h3
`define NIPC_VEC_EI2 4'h4
`define NIPC_NUM_VEC 14
`define NIPC_WAKE_ANY 14'h111c
`define NIPC_WAKE_ACTIVE 14'h0002
`define NIPC_PIN_EI0 16'h003f
`define NIPC_PIN_EI1 16'h03c0
`define NIPC_PIN_EI2 16'hfc00
`define NIPC_PIN_PD_INV 16'h0038
`define NIPC_PIN_PC_INV 16'h1c00
`endif

// ---- nipc_pkg.sv ----
// state types of the priority controller
package nipc_pkg;
    typedef struct packed {
        logic [15:0] stage1;
        logic [15:0] level;
        logic [15:0] prev;
    } nipc_sync_t;

    typedef struct packed {
        logic [7:0] bank0;
        logic [7:0] bank1;
        logic [7:0] bank2;
        logic [3:0] bank3_lo;
        logic [7:0] ext_sense;
        logic [1:0] cc;
        logic [2:0] ext_latch;
        logic irq_req;
        logic [3:0] irq_vec;
        logic [15:0] vec_addr;
        logic wake;
        logic [7:0] rdata;
    } nipc_state_t;
endpackage : nipc_pkg

// ---- nipc_pin_sync.sv ----
// two-stage synchroniser and previous-level store for the external pins
`timescale 1ns/100ps
`include "nipc_regs.svh"
module nipc_pin_sync
    import nipc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [15:0] pin_async,
    output logic [15:0] pin_level,
    output logic [15:0] pin_prev
);
    nipc_sync_t st;
    nipc_sync_t next_st;

    always_comb begin
        next_st = st;
        next_st.stage1 = pin_async;
        next_st.level = st.stage1;
        next_st.prev = st.level;
    end

    // pins idle high so no false falling edge after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '{stage1: 16'hffff, level: 16'hffff, prev: 16'hffff};
        end else begin
            st <= next_st;
        end
    end

    assign pin_level = st.level;
    assign pin_prev = st.prev;
endmodule : nipc_pin_sync

// ---- nipc_cpu_model.sv ----
// cpu core model that acknowledges interrupt requests promptly or slowly
`timescale 1ns/100ps
module nipc_cpu_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic irq_req,
    input wire logic [3:0] irq_vector,
    input wire logic ack_on,
    input wire logic slow,
    output logic irq_ack,
    output logic [3:0] last_vec
);
    logic [1:0] cnt;
    // ack lasts one cycle; the vector is taken only at an edge where the request stands
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_ack <= 1'b0;
            cnt <= 2'd0;
            last_vec <= 4'h0;
        end else if (irq_ack) begin
            irq_ack <= 1'b0;
            cnt <= 2'd0;
            if (irq_req) begin
                last_vec <= irq_vector;
            end
        end else if (ack_on && irq_req && (!slow || cnt == 2'd3)) begin
            irq_ack <= 1'b1;
        end else begin
            cnt <= irq_req ? cnt + 2'd1 : 2'd0;
        end
    end
endmodule : nipc_cpu_model

// ---- nipc_top_test.sv ----
// self-checking testbench of the nested interrupt priority controller
`timescale 1ns/100ps
module nipc_top_test;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, irq_ack, irq_req;
    logic wake_req, pu, pl, bm, bu, halt_mode, ack_on, slow, ah;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, sh;
    logic [13:0] src_req;
    logic [15:0] ext_pin, ext_pin_sel, forced, irq_vector_addr, rnd;
    logic [5:0] instr;
    logic [1:0] restore_prio;
    logic [3:0] irq_vector, last_vec, ev;
    logic [11:0] tab;
    int error_cnt, checks_done;

    nipc_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .src_req(src_req), .ext_pin(ext_pin), .ext_pin_sel(ext_pin_sel),
        .ext_pin_forced_low(forced), .halt_mode(halt_mode), .active_halt(ah),
        .enable_irq_instr(instr[0]), .disable_irq_instr(instr[1]), .instr_halt(instr[2]),
        .wait_for_irq_instr(instr[3]), .instr_trap(instr[4]), .instr_restore(instr[5]),
        .restore_prio(restore_prio), .irq_ack(irq_ack), .irq_req(irq_req),
        .irq_vector(irq_vector), .irq_vector_addr(irq_vector_addr), .wake_req(wake_req),
        .priority_upper_bit(pu), .priority_lower_bit(pl), .branch_if_masked(bm),
        .branch_if_unmasked(bu));
    nipc_cpu_model cpu_u (.pclk(pclk), .presetn(presetn), .irq_req(irq_req),
        .irq_vector(irq_vector), .ack_on(ack_on), .slow(slow), .irq_ack(irq_ack),
        .last_vec(last_vec));

    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : lfsr
    function automatic logic [7:0] fix(input logic [7:0] o, input logic [7:0] n);
        for (int p = 0; p < 4; p++) begin
            if (n[2*p+:2] != 2'b10) begin
                o[2*p+:2] = n[2*p+:2];
            end
        end
        return o;
    endfunction : fix
    function automatic int rk(input logic [1:0] p);
        return (p == 2'b10) ? 0 : (p == 2'b01) ? 1 : (p == 2'b00) ? 2 : 3;
    endfunction : rk
    // winner at level 0: highest rank, lowest vector on ties
    function automatic logic [3:0] pick(input logic [13:0] r, input logic [27:0] pr);
        int best;
        best = 0;
        pick = 4'h0;
        for (int v = 1; v < 14; v++) begin
            if (r[v] && rk(pr[2*v+:2]) > best) begin
                best = rk(pr[2*v+:2]);
                pick = 4'(v);
            end
        end
    endfunction : pick

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up
    task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            chk("pready", {31'h0, pready}, 32'h1);
            wrap_up();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wt(input logic e);
        int n;
        n = 0;
        while (irq_req !== e && n < 40) begin
            @(posedge pclk);
            n++;
        end
        if (irq_req !== e) begin
            chk("irq_req wait", {31'h0, irq_req}, {31'h0, e});
            wrap_up();
        end
    endtask : wt
    task automatic ins(input int i, input logic [1:0] rp);
        @(posedge pclk);
        instr <= 6'b1 << i;
        restore_prio <= rp;
        @(posedge pclk);
        instr <= '0;
        @(posedge pclk);
    endtask : ins
    task automatic cp(input logic [1:0] e);
        chk("priority", {30'h0, pu, pl}, {30'h0, e});
        chk("branch flags", {30'h0, bm, bu}, {30'h0, e == 2'b11, e != 2'b11});
    endtask : cp
    task automatic ack;
        ack_on <= 1'b1;
        wt(1'b0);
        ack_on <= 1'b0;
    endtask : ack

    initial begin
        {psel, penable, pwrite, halt_mode, ack_on, slow, err, ah} = '0;
        {paddr, pwdata, src_req, ext_pin_sel, forced, instr, restore_prio} = '0;
        ext_pin = 16'hffff;
        rnd = 16'hde71;
        tab = {2'b01, 2'b11, 2'b10, 2'b10, 2'b11, 2'b10};
        error_cnt = 0;
        checks_done = 0;
        presetn = 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            apb(12'h090 + 12'(4 * i), 1'b0, 8'h00);
            chk("bank reset", rd, 32'hff);
        end
        apb(12'h0a0, 1'b0, 8'h00);
        chk("sense reset", rd, 32'h0);
        cp(2'b11);
        apb(12'h0c0, 1'b0, 8'h00);
        chk("status", rd, 32'hc0);
        apb(12'h0f0, 1'b0, 8'h00);
        chk("unmapped err", {31'h0, err}, 32'h1);
        apb(12'h090, 1'b1, 8'hcf);
        apb(12'h090, 1'b1, 8'h64);
        apb(12'h090, 1'b0, 8'h00);
        chk("bank0", rd, 32'h44);
        apb(12'h09c, 1'b1, 8'h00);
        apb(12'h09c, 1'b0, 8'h00);
        chk("bank3", rd, 32'hf0);
        sh = 32'hf0ffff44;
        $display("test registers done");
        for (int i = 0; i < 6; i++) begin
            ins(i, 2'b01);
            cp(tab[2*i+:2]);
        end
        apb(12'h0a0, 1'b1, 8'hff);
        apb(12'h0a0, 1'b0, 8'h00);
        chk("sense locked", rd, 32'h0);
        ins(1, 2'b00);
        apb(12'h0a0, 1'b1, 8'hff);
        apb(12'h0a0, 1'b0, 8'h00);
        chk("sense open", rd, 32'hff);
        apb(12'h0a0, 1'b1, 8'h00);
        $display("test levels done");
        for (int k = 0; k < 8; k++) begin
            for (int b = 0; b < 4; b++) begin
                rnd = lfsr(rnd);
                apb(12'h090 + 12'(4 * b), 1'b1, rnd[7:0]);
                sh[8*b+:8] = fix(sh[8*b+:8], rnd[7:0]);
            end
            sh[31:28] = 4'hf;
            apb(12'h090 + 12'(4 * (k % 4)), 1'b0, 8'h00);
            chk("bank", rd, {24'h0, sh[8*(k%4)+:8]});
            ins(0, 2'b00);
            rnd = lfsr(rnd);
            src_req <= ({rnd[13:1], 1'b0} | (14'h1 << (k + 1)));
            ev = pick({rnd[13:1], 1'b0} | (14'h1 << (k + 1)), sh[27:0]);
            slow <= k[0];
            wt(1'b1);
            chk("vector", {28'h0, irq_vector}, {28'h0, ev});
            chk("vector addr", {16'h0, irq_vector_addr}, {16'h0, 16'hfffa - 16'(2 * ev)});
            ack();
            chk("acked", {28'h0, last_vec}, {28'h0, ev});
            cp(sh[2*ev+:2]);
            src_req <= '0;
        end
        $display("test arbitration done");
        ins(1, 2'b00);
        src_req <= 14'h1;
        wt(1'b1);
        chk("stop vector", {12'h0, irq_vector_addr, irq_vector}, 32'hfffa0);
        ins(5, 2'b01);
        ack();
        src_req <= '0;
        cp(2'b11);
        apb(12'h090, 1'b1, 8'h55);
        apb(12'h0a0, 1'b1, 8'h04);
        ext_pin_sel <= 16'h0001;
        repeat (4) @(posedge pclk);
        ext_pin <= 16'hfffe;
        repeat (6) @(posedge pclk);
        ins(0, 2'b00);
        wt(1'b1);
        chk("edge vector", {28'h0, irq_vector}, 32'h2);
        ack();
        cp(2'b01);
        ins(5, 2'b10);
        repeat (4) @(posedge pclk);
        chk("edge cleared", {31'h0, irq_req}, 32'h0);
        // grounded pin masks, sense change clears pending
        ins(1, 2'b00);
        forced <= 16'h0001;
        ext_pin <= 16'hffff;
        repeat (5) @(posedge pclk);
        ext_pin <= 16'hfffe;
        repeat (5) @(posedge pclk);
        ins(0, 2'b00);
        repeat (4) @(posedge pclk);
        chk("masked group", {31'h0, irq_req}, 32'h0);
        ins(1, 2'b00);
        apb(12'h0a0, 1'b1, 8'h02);
        forced <= '0;
        ins(0, 2'b00);
        repeat (4) @(posedge pclk);
        chk("pending cleared", {31'h0, irq_req}, 32'h0);
        // inverted low code gives high-level request on d4
        ins(1, 2'b00);
        apb(12'h0a0, 1'b1, 8'h01);
        ext_pin_sel <= 16'h0008;
        ins(0, 2'b00);
        wt(1'b1);
        chk("high level", {28'h0, irq_vector}, 32'h2);
        $display("test external done");
        ext_pin_sel <= '0;
        halt_mode <= 1'b1;
        src_req <= 14'h0020;
        repeat (4) @(posedge pclk);
        chk("no wake", {31'h0, wake_req}, 32'h0);
        src_req <= 14'h0100;
        repeat (4) @(posedge pclk);
        chk("wake", {31'h0, wake_req}, 32'h1);
        src_req <= 14'h0002;
        repeat (4) @(posedge pclk);
        chk("plain halt", {31'h0, wake_req}, 32'h0);
        ah <= 1'b1;
        repeat (4) @(posedge pclk);
        chk("active halt", {31'h0, wake_req}, 32'h1);
        halt_mode <= 1'b0;
        src_req <= '0;
        $display("test wake done");
        wrap_up();
    end
endmodule : nipc_top_test
